// *** logic/ddr3_dev_defines.vh ***
// Purpose: constants for the DRAM command-side model
// Assumes: DRAM clock sampled by the 100 MHz core clock
// Notes: mode register and command encodings, timing counts in DRAM clocks
`ifndef DDR3_DEV_DEFINES_VH
`define DDR3_DEV_DEFINES_VH
// ***************
// Command codes {ras_n, cas_n, we_n}
// ***************
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_NOP 3'h7
// ***************
// Mode register fields
// ***************
`define MR_SEL_MR0 3'h0
`define MR_SEL_MR1 3'h1
`define MR1_LEVEL_BIT 7
`define MR1_QOFF_BIT 12
`define MR0_BL_LSB 0
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_CHOP_BIT 12
// ***************
// Timing in DRAM clocks; burst lengths in beats
// ***************
`define T_MOD_CK 12
`define T_RP_CK 11
`define T_WLO_CK 2'h1
`define BEATS_BC4 4
`define BEATS_BL8 8
`endif

// *** logic/bank_table.v ***
// Purpose: per-bank open row and precharge timers
// Assumes: one command a DRAM clock via i_ck_en
// Notes: rows readable from registers
`timescale 1ns/1ns
`include "ddr3_dev_defines.vh"
module bank_table #(
  parameter BANKS = 8,
  parameter ROW_W = 15,
  parameter TRP = `T_RP_CK
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_ck_en,
  input wire i_act,
  input wire i_pre,
  input wire i_pre_all,
  input wire [2:0] i_bank,
  input wire [ROW_W-1:0] i_row,
  output reg [BANKS-1:0] o_open,
  output reg [BANKS-1:0] o_ready,
  output reg [ROW_W-1:0] o_row
);
  reg [ROW_W-1:0] rows [0:BANKS-1];
  wire [BANKS-1:0] bank_hit;
  genvar g;
  // One-hot bank select, so no slice of the loop index is needed
  assign bank_hit = {{(BANKS-1){1'b0}}, 1'b1} << i_bank;
  // ***************
  // One slot per bank
  // ***************
  generate
    for (g = 0; g < BANKS; g = g + 1) begin : bank
      reg [7:0] pre_cnt;
      wire hit;
      assign hit = bank_hit[g];
      always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          o_open[g] <= 1'b0;
          o_ready[g] <= 1'b1;
          pre_cnt <= 8'h00;
        end else if (i_ck_en) begin
          if (i_act && hit && o_ready[g]) begin
            o_open[g] <= 1'b1;
            rows[g] <= i_row;
          end else if (i_pre && (hit || i_pre_all)) begin
            // Restarts on every precharge, idle or not
            o_open[g] <= 1'b0;
            o_ready[g] <= 1'b0;
            pre_cnt <= TRP[7:0];
          end else if (pre_cnt != 8'h00) begin
            pre_cnt <= pre_cnt - 8'h01;
            o_ready[g] <= (pre_cnt == 8'h01);
          end
        end
      end
    end
  endgenerate
  // Row of the selected bank, registered
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_row <= {ROW_W{1'b0}};
    end else begin
      o_row <= rows[i_bank];
    end
  end
endmodule

// *** logic/burst_gen.v ***
// Purpose: read burst beat generator with latency delay
// Assumes: i_ck_en marks DRAM clock rising edges, i_half both edges
// Notes: one beat per strobe edge
`timescale 1ns/1ns
`include "ddr3_dev_defines.vh"
module burst_gen (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_ck_en,
  input wire i_half,
  input wire i_start,
  input wire [4:0] i_lat,
  input wire i_chop,
  output reg o_active,
  output reg o_strobe,
  output reg [3:0] o_beat
);
  reg [4:0] wait_cnt;
  reg pending;
  reg chop;
  // Latency count then beats on each edge
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wait_cnt <= 5'h00;
      pending <= 1'b0;
      chop <= 1'b0;
      o_active <= 1'b0;
      o_strobe <= 1'b0;
      o_beat <= 4'h0;
    end else begin
      if (i_start && i_ck_en) begin
        pending <= 1'b1;
        chop <= i_chop;
        wait_cnt <= i_lat;
      end else if (pending && i_ck_en) begin
        if (wait_cnt <= 5'h01) begin
          pending <= 1'b0;
          o_active <= 1'b1;
          o_beat <= 4'h0;
          o_strobe <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 5'h01;
        end
      end else if (o_active && i_half) begin
        // Strobe toggles each edge, one beat per edge
        if (o_beat == (chop ? 4'h3 : 4'h7)) begin
          o_active <= 1'b0;
          o_strobe <= 1'b0;
        end else begin
          o_beat <= o_beat + 4'h1;
          o_strobe <= ~o_strobe;
        end
      end
    end
  end
endmodule

// *** logic/ddr3_dev.v ***
// Purpose: DRAM command side: leveling, banks, burst length
// Assumes: pins synchronised here; one command per DRAM clock
// Notes: status via APB; data payload is a beat index pattern
//
// Behaviour
// - MR1 write with A7 high enters leveling, A7 low leaves it.
// - In leveling, ODT switches strobe termination only; data stays off.
// - Data pins undefined on leveling entry until feedback.
// - Each strobe rise samples clock, drives it on all data bits.
// - After exit MRS, data undefined until mode update delay passes.
// - Activate opens row A0-A14 in bank BA0-BA2.
// - Precharge closes one or all banks; reopen after precharge time.
// - Precharge to idle bank accepted; timer restarts from latest.
// - On-the-fly mode: A12 low chops to 4 beats, high 8.
// - 8 beats from fixed field 00 or field 01 with A12 high.
`timescale 1ns/1ns
`include "ddr3_dev_defines.vh"
module ddr3_dev #(
  parameter ROW_W = 15,
  parameter TMOD = `T_MOD_CK
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_ck,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [2:0] i_ba,
  input wire [ROW_W-1:0] i_addr,
  input wire i_odt,
  input wire i_dqs,
  input wire [7:0] i_dq,
  output reg [7:0] o_dq,
  output reg o_dq_oe_n,
  output reg o_dq_undef,
  output reg o_dqs,
  output reg o_dqs_oe_n,
  output reg o_dqs_term,
  output reg o_dq_term,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output reg o_pslverr
);
  // ***************
  // APB map
  // ***************
  // Word offsets, one register each
  localparam [11:0] A_STATUS = 12'h000;
  localparam [11:0] A_BANKS = 12'h004;
  localparam [11:0] A_LAT = 12'h008;
  localparam [11:0] A_ROW = 12'h00C;
  localparam [11:0] A_LEVEL = 12'h010;
  // ***************
  // Pin synchronisers
  // ***************
  // First stage only feeds the second stage
  reg [4:0] s1;
  reg [4:0] s2;
  reg ck_q;
  reg [2:0] cmd_s1;
  reg [2:0] cmd_s2;
  reg [2:0] ba_s1;
  reg [2:0] ba_s2;
  reg [ROW_W-1:0] a_s1;
  reg [ROW_W-1:0] a_s2;
  wire ck_s;
  wire cs_n_s;
  wire odt_s;
  wire dqs_s;
  reg dqs_q;
  assign ck_s = s2[0];
  assign cs_n_s = s2[1];
  assign odt_s = s2[2];
  assign dqs_s = s2[3];
  // Two stages for every pin except the data lines; command, bank and address buses sampled alongside
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s1 <= 5'h02;
      s2 <= 5'h02;
      cmd_s1 <= `CMD_NOP;
      cmd_s2 <= `CMD_NOP;
      ba_s1 <= 3'h0;
      ba_s2 <= 3'h0;
      a_s1 <= {ROW_W{1'b0}};
      a_s2 <= {ROW_W{1'b0}};
      ck_q <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      s1 <= {1'b0, i_dqs, i_odt, i_cs_n, i_ck};
      s2 <= s1;
      cmd_s1 <= {i_ras_n, i_cas_n, i_we_n};
      cmd_s2 <= cmd_s1;
      ba_s1 <= i_ba;
      ba_s2 <= ba_s1;
      a_s1 <= i_addr;
      a_s2 <= a_s1;
      ck_q <= ck_s;
      dqs_q <= dqs_s;
    end
  end
  // Edge enables of the sampled DRAM clock and strobe
  wire ck_rise;
  wire ck_fall;
  wire dqs_rise;
  assign ck_rise = ck_s & ~ck_q;
  assign ck_fall = ~ck_s & ck_q;
  assign dqs_rise = dqs_s & ~dqs_q;
  // ***************
  // Command decode
  // ***************
  // Valid only on a sampled clock rise with chip select low
  wire cmd_v;
  wire is_mrs;
  wire is_act;
  wire is_pre;
  wire is_rd;
  assign cmd_v = ck_rise & ~cs_n_s;
  assign is_mrs = cmd_v & (cmd_s2 == `CMD_MRS);
  assign is_act = cmd_v & (cmd_s2 == `CMD_ACT);
  assign is_pre = cmd_v & (cmd_s2 == `CMD_PRE);
  assign is_rd = cmd_v & (cmd_s2 == `CMD_RD);
  // ***************
  // Mode registers
  // ***************
  reg [1:0] bl_mode;
  reg level;
  reg qoff;
  reg [4:0] lat;
  reg [7:0] mod_cnt;
  reg fb_seen;
  // ***************
  // Mode register write strobes
  // ***************
  wire mr0_wr;
  wire mr1_wr;
  wire lvl_exit;
  // Bank inputs pick the mode register being written
  assign mr0_wr = is_mrs & (ba_s2 == `MR_SEL_MR0);
  assign mr1_wr = is_mrs & (ba_s2 == `MR_SEL_MR1);
  // Exit write seen while still leveling: data turns undefined at once
  assign lvl_exit = mr1_wr & level & ~a_s2[`MR1_LEVEL_BIT];
  // MRS writes; leveling entry and exit by MR1 bit 7
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      bl_mode <= `BL_FIXED8;
      level <= 1'b0;
      qoff <= 1'b0;
    end else if (mr0_wr) begin
      bl_mode <= a_s2[`MR0_BL_LSB+1:`MR0_BL_LSB];
    end else if (mr1_wr) begin
      level <= a_s2[`MR1_LEVEL_BIT];
      qoff <= a_s2[`MR1_QOFF_BIT];
    end
  end
  // Update delay after any MR1 write, in DRAM clocks
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mod_cnt <= 8'h00;
    end else if (mr1_wr) begin
      // Entry write restarts it too; only after the exit does it hold data undefined
      mod_cnt <= TMOD[7:0];
    end else if (ck_rise && mod_cnt != 8'h00) begin
      mod_cnt <= mod_cnt - 8'h01;
    end
  end
  // ***************
  // Leveling feedback
  // ***************
  reg [1:0] wlo_cnt;
  reg cap;
  reg sample;
  // Strobe rise catches clock level; shown after output delay
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      fb_seen <= 1'b0;
      cap <= 1'b0;
      sample <= 1'b0;
      wlo_cnt <= 2'h0;
    end else if (!level) begin
      fb_seen <= 1'b0;
      wlo_cnt <= 2'h0;
    end else if (dqs_rise) begin
      cap <= ck_s;
      wlo_cnt <= `T_WLO_CK;
    end else if (ck_rise && wlo_cnt != 2'h0) begin
      // Counted in DRAM clocks, not core clocks
      wlo_cnt <= wlo_cnt - 2'h1;
      if (wlo_cnt == 2'h1) begin
        sample <= cap;
        fb_seen <= 1'b1;
      end
    end
  end
  // ***************
  // Banks and reads
  // ***************
  wire [7:0] open_b;
  wire [7:0] ready_b;
  wire [ROW_W-1:0] row_sel;
  wire rd_ok;
  wire chop;
  // Bank whose row feeds read data between commands
  reg [2:0] rd_bank;
  // Bank index follows the command, else the last read
  bank_table #(
    .BANKS(8),
    .ROW_W(ROW_W),
    .TRP(`T_RP_CK)
  ) u_banks (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ck_en(ck_rise),
    .i_act(is_act & ~level),
    .i_pre(is_pre & ~level),
    .i_pre_all(a_s2[10]),
    .i_bank(cmd_v ? ba_s2 : rd_bank),
    .i_row(a_s2),
    .o_open(open_b),
    .o_ready(ready_b),
    .o_row(row_sel)
  );
  // Reads only to an open bank; other banks free meanwhile
  assign rd_ok = is_rd & ~level & open_b[ba_s2];
  // Chop only in on-the-fly mode with A12 low
  assign chop = (bl_mode == `BL_OTF) & ~a_s2[`BL_CHOP_BIT];
  // Beat data is the low row nibble and the beat index
  wire b_act;
  wire b_strobe;
  wire [3:0] b_beat;
  burst_gen u_burst (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ck_en(ck_rise),
    .i_half(ck_rise | ck_fall),
    .i_start(rd_ok),
    .i_lat(lat),
    .i_chop(chop),
    .o_active(b_act),
    .o_strobe(b_strobe),
    .o_beat(b_beat)
  );
  // Remember bank of last read
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rd_bank <= 3'h0;
    end else if (rd_ok) begin
      rd_bank <= ba_s2;
    end
  end
  // ***************
  // Pin drivers
  // ***************
  // Registered pins; strobe termination follows the synchronised ODT, data termination only outside leveling
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_dq <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_dq_undef <= 1'b0;
      o_dqs <= 1'b0;
      o_dqs_oe_n <= 1'b1;
      o_dqs_term <= 1'b0;
      o_dq_term <= 1'b0;
    end else begin
      o_dqs_term <= odt_s;
      o_dq_term <= odt_s & ~level;
      if (level) begin
        // Undefined until first feedback, and again from the exit write
        o_dq_undef <= ~fb_seen | lvl_exit;
        o_dq <= {8{sample}};
        o_dq_oe_n <= ~fb_seen | qoff;
        // The strobe belongs to the controller while leveling
        o_dqs <= 1'b0;
        o_dqs_oe_n <= 1'b1;
      end else if (b_act) begin
        o_dq_undef <= 1'b0;
        o_dq <= {row_sel[3:0], b_beat};
        o_dq_oe_n <= 1'b0;
        o_dqs <= b_strobe;
        o_dqs_oe_n <= 1'b0;
      end else begin
        // Stays undefined through the update delay after exit
        o_dq_undef <= (mod_cnt != 8'h00) & o_dq_undef;
        o_dq_oe_n <= 1'b1;
        o_dqs <= 1'b0;
        o_dqs_oe_n <= 1'b1;
      end
    end
  end
  // ***************
  // APB slave, zero wait
  // ***************
  wire wr_acc;
  // Always ready; a write lands on its access edge
  assign o_pready = 1'b1;
  assign wr_acc = i_psel & i_penable & i_pwrite;
  // Latency register writable; default 5
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      lat <= 5'h05;
    end else if (wr_acc && i_paddr == A_LAT) begin
      lat <= i_pwdata[4:0];
    end
  end
  // Read mux
  always @* begin
    o_pslverr = 1'b0;
    if (i_paddr == A_STATUS) begin
      o_prdata = {26'h0, bl_mode, b_act, qoff, mod_cnt != 8'h00, level};
    end else if (i_paddr == A_BANKS) begin
      o_prdata = {16'h0, ready_b, open_b};
    end else if (i_paddr == A_LAT) begin
      o_prdata = {27'h0, lat};
    end else if (i_paddr == A_ROW) begin
      o_prdata = {{(32-ROW_W){1'b0}}, row_sel};
    end else if (i_paddr == A_LEVEL) begin
      o_prdata = {30'h0, fb_seen, sample};
    end else begin
      // Unmapped: refused, data zero
      o_prdata = 32'h0;
      o_pslverr = i_psel & i_penable;
    end
  end
  // Write data path not modelled; the pins are only loaded
  wire unused_dq;
  assign unused_dq = ^i_dq;
endmodule

// *** tb/ddr3_dev_props.sv ***
// Purpose: port checks for the DRAM command block
// Assumes: one core clock, sync reset high
// Notes: bound to every ddr3_dev below
`timescale 1ns/1ns
module ddr3_dev_props #(
  parameter ROW_W = 15,
  parameter TMOD = 12
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_odt,
  input wire i_psel,
  input wire i_penable,
  input wire [11:0] i_paddr,
  input wire [7:0] o_dq,
  input wire o_dq_oe_n,
  input wire o_dq_undef,
  input wire o_dqs_oe_n,
  input wire o_dqs_term,
  input wire o_dq_term,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr
);
  // ****
  // Checks on the core clock
  // ****
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Access phase of an APB transfer
  wire acc = i_psel && i_penable;
  zero_wait_a: assert property (acc |-> o_pready)
    else $error("access not ready");
  bad_addr_a: assert property (acc && i_paddr > 12'h010 |-> o_pslverr)
    else $error("unmapped access accepted");
  good_addr_a: assert property (acc && i_paddr[1:0] == 2'h0 &&
    i_paddr <= 12'h010 |-> !o_pslverr) else $error("mapped access refused");
  err_data_a: assert property (acc && o_pslverr |-> o_prdata == 32'h0)
    else $error("refused read data not zero");
  reset_out_a: assert property ($fell(i_sys_rst) |-> o_dq_oe_n &&
    o_dqs_oe_n && !o_dq_undef) else $error("pins driven after reset");
  fb_level_a:
    assert property (!o_dq_oe_n && o_dqs_oe_n |-> o_dq == 8'h00 ||
      o_dq == 8'hFF) else $error("feedback bits differ");
  odt_off_a:
    assert property ((!i_odt) [*8] |-> !o_dqs_term && !o_dq_term)
      else $error("termination on without odt");
  undef_term_a:
    assert property (o_dq_undef |-> !o_dq_term)
      else $error("data termination while undefined");
  strobe_min_a:
    assert property ($fell(o_dqs_oe_n) |-> (!o_dqs_oe_n) [*8])
      else $error("read strobe cut short");
endmodule

bind ddr3_dev ddr3_dev_props #(.ROW_W(ROW_W), .TMOD(TMOD)) props_inst (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_odt(i_odt),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
  .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_dq_undef(o_dq_undef),
  .o_dqs_oe_n(o_dqs_oe_n), .o_dqs_term(o_dqs_term),
  .o_dq_term(o_dq_term), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr)
);

// *** tb/ctl.sv ***
// Purpose: DRAM controller seen from the device pins
// Assumes: clock runs free at 160 ns, one command a clock
// Notes: bench calls the tasks; released lines show the inverse
`timescale 1ns/1ns
module ctl (
  input wire [7:0] i_dq,
  output logic o_ck,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [2:0] o_ba,
  output logic [14:0] o_addr,
  output logic o_odt,
  output logic o_dqs
);
  // ****
  // Clock and pin tasks
  // ****
  // Offset start so clock edges never coincide with core clock edges
  initial begin
    {o_ck, o_odt, o_dqs} = 3'h0;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    {o_ba, o_addr} = 18'h0;
    #3;
    forever #80 o_ck = ~o_ck;
  end
  task ticks(input int n);
    repeat (n) @(posedge o_ck);
  endtask
  // Held across one rising edge, then deselect
  task cmd(input logic [2:0] c, input logic [2:0] b,
    input logic [14:0] a);
    @(negedge o_ck);
    {o_ras_n, o_cas_n, o_we_n} = c;
    {o_cs_n, o_ba, o_addr} = {1'b0, b, a};
    @(negedge o_ck);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    {o_ba, o_addr} = ~{b, a};
  endtask
  task set_odt(input logic v);
    @(negedge o_ck);
    o_odt = v;
  endtask
  // The controller drives the idle strobe low itself
  task pulse(input int d);
    @(posedge o_ck);
    #(d) o_dqs = 1'b1;
    #40 o_dqs = 1'b0;
    ticks(3);
  endtask
  // Step strobe delay until feedback goes 0 to 1
  task sweep(output int lock);
    logic prev;
    lock = -1;
    prev = 1'b1;
    for (int i = 0; i < 4 && lock < 0; i++) begin
      pulse(120 + 80 * i);
      if (!prev && i_dq[0]) lock = i;
      prev = i_dq[0];
    end
  endtask
endmodule

// *** tb/ddr3_dev_bench.sv ***
// Purpose: self-checking bench for the DRAM command block
// Assumes: core clock 100 MHz, DRAM clock from the model
// Notes: read latency set to 7; row nibble 5 marks beats
`timescale 1ns/1ns
`include "ddr3_dev_defines.vh"
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); \
  end \
end
module ddr3_dev_bench;
  logic clk, rst, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire ck, cs_n, ras_n, cas_n, we_n, odt, dqs, dq_oe_n, undef;
  wire dqs_o, dqs_oe_n, dqs_term, dq_term, pready, pslverr;
  wire [2:0] ba;
  wire [14:0] addr;
  wire [7:0] dq;
  wire [31:0] prdata;
  wire [7:0] dq_pin;
  int bad_count, n_tests;
  // Released data lines show the inverse, so stale values cannot pass
  assign dq_pin = dq_oe_n ? ~dq : dq;
  ddr3_dev ddr3_dev_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_ck(ck), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba),
    .i_addr(addr), .i_odt(odt), .i_dqs(dqs), .i_dq(dq_pin),
    .o_dq(dq), .o_dq_oe_n(dq_oe_n), .o_dq_undef(undef),
    .o_dqs(dqs_o), .o_dqs_oe_n(dqs_oe_n), .o_dqs_term(dqs_term),
    .o_dq_term(dq_term), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  ctl ctl_inst (
    .i_dq(dq_pin), .o_ck(ck), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr),
    .o_odt(odt), .o_dqs(dqs));
  // ****
  // Bus and closing tasks
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    $display("bad %0d of %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task hang;
    bad_count++;
    stop_test;
  endtask
  // Request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (k >= 50) hang;
  endtask
  // ****
  // Scenarios
  // ****
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd[0], 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, 33'h100000000);
  endtask
  task t_level;
    int lk;
    ctl_inst.cmd(`CMD_MRS, 3'h1, 15'h0084);
    ctl_inst.ticks(`T_MOD_CK);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd[0], 1'b1);
    `CHK(undef, 1'b1);
    ctl_inst.cmd(`CMD_ACT, 3'h2, 15'h0001);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[2], 1'b0);
    ctl_inst.set_odt(1'b1);
    ctl_inst.ticks(2);
    `CHK({dqs_term, dq_term}, 2'b10);
    ctl_inst.sweep(lk);
    `CHK(lk, 1);
    `CHK({dq_oe_n, dq}, 9'h0FF);
    ctl_inst.set_odt(1'b0);
    ctl_inst.ticks(2);
    `CHK({dqs_term, dq_term}, 2'b00);
    ctl_inst.cmd(`CMD_MRS, 3'h1, 15'h0004);
    ctl_inst.ticks(`T_MOD_CK - 2);
    `CHK(undef, 1'b1);
    ctl_inst.ticks(4);
    `CHK(undef, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd[0], 1'b0);
  endtask
  // Output buffer off: leveling runs but feedback stays undriven
  task t_rank;
    ctl_inst.cmd(`CMD_MRS, 3'h1, 15'h1084);
    ctl_inst.ticks(`T_MOD_CK);
    apb(1'b0, 12'h000, 32'h0);
    `CHK({rd[2], rd[0]}, 2'b11);
    ctl_inst.pulse(200);
    `CHK(dq_oe_n, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd[1:0], 2'b11);
    ctl_inst.cmd(`CMD_MRS, 3'h1, 15'h0004);
    ctl_inst.ticks(`T_MOD_CK + 2);
    `CHK(undef, 1'b0);
  endtask
  // Second precharge restarts the timer
  task t_bank;
    ctl_inst.cmd(`CMD_ACT, 3'h3, 15'h7FF5);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[3], 1'b1);
    ctl_inst.cmd(`CMD_PRE, 3'h3, 15'h0);
    ctl_inst.ticks(4);
    ctl_inst.cmd(`CMD_PRE, 3'h3, 15'h0);
    ctl_inst.ticks(`T_RP_CK - 4);
    ctl_inst.cmd(`CMD_ACT, 3'h3, 15'h7FF5);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[3], 1'b0);
    ctl_inst.ticks(4);
    ctl_inst.cmd(`CMD_ACT, 3'h3, 15'h7FF5);
    ctl_inst.cmd(`CMD_ACT, 3'h5, 15'h0001);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[7:0], 8'h28);
    ctl_inst.cmd(`CMD_PRE, 3'h0, 15'h0400);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[7:0], 8'h00);
    ctl_inst.ticks(`T_RP_CK + 1);
  endtask
  task burst(input logic [1:0] bl, input logic a12, input int n);
    int k, got;
    logic [7:0] pv;
    ctl_inst.cmd(`CMD_MRS, 3'h0, {13'h0, bl});
    ctl_inst.ticks(`T_MOD_CK);
    ctl_inst.cmd(`CMD_RD, 3'h1, {2'b0, a12, 12'h0});
    ctl_inst.ticks(6);
    repeat (6) @(posedge clk);
    `CHK(dq_oe_n, 1'b1);
    ctl_inst.ticks(1);
    repeat (6) @(posedge clk);
    `CHK({dq_oe_n, dq}, 9'h050);
    `CHK({dqs_oe_n, dqs_o}, 2'b01);
    pv = dq;
    got = 1;
    for (k = 0; k < 400 && !dq_oe_n; k++) begin
      @(posedge clk);
      if (!dq_oe_n && dq !== pv) begin
        got++;
        pv = dq;
      end
    end
    if (k == 400) hang;
    `CHK(dqs_oe_n, 1'b1);
    `CHK(got, n);
    `CHK(pv, 8'h4F + n);
  endtask
  task t_read;
    apb(1'b1, 12'h008, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd[4:0], 5'h07);
    ctl_inst.cmd(`CMD_ACT, 3'h1, 15'h0005);
    burst(`BL_OTF, 1'b1, 8);
    burst(`BL_OTF, 1'b0, 4);
    burst(`BL_FIXED8, 1'b0, 8);
  endtask
  // Reset for 20 cycles, then the scenarios
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {3'b100, 45'h0};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_level;
    t_rank;
    t_bank;
    t_read;
    stop_test;
  end
endmodule
